// *** bench/tb_tta_top.sv ***
// self-checking bench of the tile test access port, driven by a behavioural test controller model
module tb_tta_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tta_pkg::*;
  localparam logic [3:0]  VER = 4'h6;      // arbitrary value
  localparam logic [15:0] PRT = 16'h3C19;  // arbitrary value
  localparam logic [10:0] MKR = 11'h15D;   // arbitrary value
  localparam logic [17:0] REV = 18'h0102B; // arbitrary value
  localparam logic [31:0] ID  = {VER, PRT, MKR, 1'h1};

  logic                         clk_i = 1'b0;
  logic                         reset_n_i = 1'b0;
  logic                         pll_lock_i = 1'b0;
  logic [TILES-1:0][WORD_W-1:0] sec_word_i = '0;
  logic [TILES-1:0][WORD_W-1:0] acc_rdata_i = '0;
  logic [TILES-1:0][BSR_W-1:0]  bs_pins_i = '0;
  logic [BOOT_W-1:0]            boot_mode_i = '0;
  wire logic                    tck_i, tms_i, tdi_i, trst_n_i, tdo_o, tdo_oe_o, boot_start_o;
  wire logic [TILES-1:0]        bs_drive_o, acc_valid_o;
  wire logic [TILES-1:0][BSR_W-1:0] bs_out_o;
  wire tta_acc_t [TILES-1:0]    acc_o;
  wire logic [BOOT_W-1:0]       boot_mode_o;
  int                           miscompares = 0;
  int                           checked = 0;
  int                           pulses = 0;
  int                           stray = 0;
  tta_acc_t                     last_acc;

  tta_top #(.ID_VERSION(VER), .ID_PART(PRT), .ID_MAKER(MKR), .SILICON_REV(REV)) DUT (
    .clk_i, .reset_n_i, .tck_i, .tms_i, .tdi_i, .trst_n_i, .tdo_o, .tdo_oe_o, .sec_word_i,
    .bs_pins_i, .bs_drive_o, .bs_out_o, .acc_valid_o, .acc_o, .acc_rdata_i, .pll_lock_i,
    .boot_mode_i, .boot_start_o, .boot_mode_o);
  tta_ctl_model ctl (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .trst_n_o(trst_n_i),
    .tdo_i(tdo_o));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (acc_valid_o[0] === 1'b1) begin
      pulses++;
      last_acc = acc_o[0];
    end
    if (acc_valid_o[1] === 1'b1) stray++;
  end

  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  initial begin
    logic [127:0] din;
    logic [127:0] dout;
    logic [31:0]  uc;
    tta_acc_t     a;
    logic         ok;
    logic         cap;
    tta_acc_t     held;
    int           exp_pulses;
    void'($urandom(53));
    exp_pulses = 0;
    din = {$urandom, $urandom, $urandom, $urandom};
    repeat (2) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    boot_mode_i = BOOT_W'($urandom);
    @(posedge clk_i);
    #1;
    pll_lock_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    check(boot_start_o, 1'h1);
    check(boot_mode_o, boot_mode_i);
    @(posedge clk_i);
    #1;
    check(boot_start_o, 1'h0);
    ctl.trst_pulse();
    ctl.scan(1'b0, 128, din, dout);
    check(dout, {4{ID}});
    ctl.scan(1'b1, 16, {4{IR_USER}}, dout);
    check(dout[15:0], {4{IR_CAPTURE}});
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      #1;
      sec_word_i[0] = (k == 0) ? 32'h0 : $urandom;
      uc = {sec_word_i[0][31:22], 4'h0, REV};
      ctl.scan(1'b0, 128, din, dout);
      check(dout, {4{uc}});
    end
    // only tile 0 chip tap in the access path; bypass taps capture zero
    ctl.scan(1'b1, 16, {IR_BYPASS, IR_ACCESS, IR_BYPASS, IR_BYPASS}, dout);
    held = '0;
    for (int k = 0; k < 6; k++) begin
      a = '{target: tta_target_t'(k < 4 ? k : 6 - k), write: 1'($urandom),
            addr: ADDR_W'($urandom), data: $urandom};
      @(posedge clk_i);
      #1;
      sec_word_i[0] = $urandom & 32'hFFFFDFFE;
      if (k == 3 || k == 4) sec_word_i[0][13] = 1'b1;
      if (k == 5) sec_word_i[0][0] = 1'b1;
      sec_word_i[1] = $urandom;
      acc_rdata_i = {$urandom, $urandom};
      ok = !sec_word_i[0][0] && !(a.target == TGT_OTP && sec_word_i[0][13]);
      // capture returns read data of the held request, judged by that request's target
      cap = !sec_word_i[0][0] && !(held.target == TGT_OTP && sec_word_i[0][13]);
      exp_pulses += int'(ok);
      ctl.scan(1'b0, 51, {1'h0, a, 2'h0}, dout);
      check(dout[50:0], {1'h0, cap ? {held[47:32], acc_rdata_i[0]} : 48'h0, 2'h0});
      repeat (8) @(posedge clk_i);
      check(pulses, exp_pulses);
      if (ok) check(last_acc, a);
      if (ok) held = a;
    end
    // drive then sample mode; only drive mode may enable the pin drivers
    for (int m = 0; m < 2; m++) begin
      ctl.scan(1'b1, 16, {m ? IR_SAMPLE : IR_EXTEST, {3{IR_BYPASS}}}, dout);
      check(bs_drive_o, m ? 2'h0 : 2'h1);
      @(posedge clk_i);
      #1;
      bs_pins_i = 16'($urandom);
      ctl.scan(1'b0, 11, din, dout);
      check(dout[10:0], {bs_pins_i[0], 3'h0});
      check(bs_out_o, {8'h0, din[10:3]});
      din = ~din;
    end
    ctl.trst_pulse();
    check({bs_drive_o, bs_out_o[0]}, 10'h0);
    ctl.scan(1'b0, 128, din, dout);
    check(dout, {4{ID}});
    check(stray, 0);
    complete_run();
  end

  // the whole sequence needs roughly 64 us of test clock traffic
  initial begin
    #300000;
    miscompares++;
    complete_run();
  end
endmodule : tb_tta_top

// *** bench/tta_ctl_model.sv ***
// external test controller model; its test clock idles low between frames
module tta_ctl_model (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_n_o,
  input  wire logic tdo_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b0;
  end

  // tdo is taken just before the rise, well after the device moved it at the fall
  task automatic tick(input logic ms, input logic di, output logic dout);
    #1;
    tms_o = ms;
    tdi_o = di;
    #31;
    dout = tdo_i;
    tck_o = 1'b1;
    #32;
    tck_o = 1'b0;
  endtask : tick

  // clocks while held are ignored by the device; ends in run-test/idle
  task automatic trst_pulse();
    logic d;
    trst_n_o = 1'b0;
    repeat (3) tick(1'h1, ~tdi_o, d);
    #100;
    trst_n_o = 1'b1;
    #25;
    tick(1'h0, ~tdi_o, d);
  endtask : trst_pulse

  // idle to capture, n shift bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic d;
    dout = '0;
    tick(1'h1, ~tdi_o, d);
    if (ir) tick(1'h1, ~tdi_o, d);
    tick(1'h0, ~tdi_o, d);
    tick(1'h0, ~tdi_o, d);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], d);
      dout[i] = d;
    end
    tick(1'h1, ~tdi_o, d);
    tick(1'h0, ~tdi_o, d);
  endtask : scan
endmodule : tta_ctl_model

// *** bench/tta_top_monitor.sv ***
// concurrent checks on the test access port, bound to the top module
module tta_top_monitor
  import tta_pkg::*;
(
  input wire logic                                        clk_i,
  input wire logic                                        reset_n_i,
  input wire logic                                        tck_i,
  input wire logic                                        trst_n_i,
  input wire logic                                        tdo_o,
  input wire logic                                        tdo_oe_o,
  input wire logic [tta_pkg::TILES-1:0][tta_pkg::WORD_W-1:0] sec_word_i,
  input wire logic [tta_pkg::TILES-1:0]                   bs_drive_o,
  input wire logic [tta_pkg::TILES-1:0]                   acc_valid_o,
  input wire tta_pkg::tta_acc_t [tta_pkg::TILES-1:0]      acc_o,
  input wire logic                                        pll_lock_i,
  input wire logic                                        boot_start_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_trst_holds_quiet: assert property (
    !trst_n_i [*5] |-> !tdo_oe_o && bs_drive_o == '0)
    else $error("test logic active while test reset held");
  a_valid_one_pulse: assert property (
    acc_valid_o[0] |=> !acc_valid_o[0])
    else $error("access strobe longer than one cycle");
  a_acc_holds: assert property (
    $changed(acc_o[0]) |-> acc_valid_o[0] || (acc_o[0] == '0 && !$past(trst_n_i)))
    else $error("access word changed without strobe");
  a_port_locked: assert property (
    acc_valid_o[0] |-> !sec_word_i[0][SEC_NO_JTAG])
    else $error("access issued while port locked");
  a_otp_locked: assert property (
    acc_valid_o[0] && acc_o[0].target == TGT_OTP |-> !sec_word_i[0][SEC_NO_OTP])
    else $error("one-time memory access issued while locked");
  a_tdo_low_phase: assert property (
    $changed(tdo_o) || $changed(tdo_oe_o) |-> !tck_i)
    else $error("tdo moved while test clock high");
  a_drive_on_update: assert property (
    $rose(bs_drive_o[0]) |-> tck_i)
    else $error("pin drive enabled outside update");
  a_boot_delay: assert property (
    boot_start_o |-> $past(pll_lock_i, 3) && !$past(pll_lock_i, 4))
    else $error("boot start not three cycles after lock");
  a_boot_once: assert property (
    boot_start_o |=> !boot_start_o [*8])
    else $error("boot start repeated");

  c_access: cover property (acc_valid_o[0]);
  c_boot: cover property (boot_start_o);
  c_drive: cover property ($rose(bs_drive_o[0]));
endmodule : tta_top_monitor

bind tta_top tta_top_monitor u_mon (.clk_i, .reset_n_i, .tck_i, .trst_n_i, .tdo_o, .tdo_oe_o,
  .sec_word_i, .bs_drive_o, .acc_valid_o, .acc_o, .pll_lock_i, .boot_start_o);

// *** rtl/tta_pkg.sv ***
// shared constants, types and helpers of the tile test access port
package tta_pkg;

  localparam int         TILES      = 2;
  localparam int         TAPS       = 2 * TILES;
  localparam int         IR_W       = 4;
  localparam int         SR_W       = 48;
  localparam int         BSR_W      = 8;
  localparam int         WORD_W     = 32;
  localparam int         ADDR_W     = 13;
  localparam int         BOOT_W     = 3;

  localparam logic [3:0] IR_EXTEST  = 4'h0;
  localparam logic [3:0] IR_SAMPLE  = 4'h1;
  localparam logic [3:0] IR_DEVICE_IDENTIFICATION_WORD  = 4'h2;
  localparam logic [3:0] IR_USER    = 4'h3;
  localparam logic [3:0] IR_ACCESS  = 4'h8;
  localparam logic [3:0] IR_BYPASS  = 4'hF;
  localparam logic [3:0] IR_RESET   = IR_DEVICE_IDENTIFICATION_WORD;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  localparam int         SEC_NO_JTAG = 0;
  localparam int         SEC_NO_OTP  = 13;
  localparam int         TAG_LSB     = 22;
  localparam int         TAG_W       = 10;
  localparam logic [3:0] UC_UNUSED   = 4'h0;

  localparam int         ID_LEN     = 32;
  localparam int         ACC_LEN    = 2 + 1 + ADDR_W + WORD_W;

  typedef enum logic [1:0] {
    TGT_TILE, TGT_SWITCH, TGT_OTP, TGT_SPARE
  } tta_target_t;

  typedef struct packed {
    tta_target_t              target;
    logic                     write;
    logic [ADDR_W-1:0]        addr;
    logic [WORD_W-1:0]        data;
  } tta_acc_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } tta_pins_t;

  typedef struct packed {
    logic [IR_W-1:0]  ir;
    logic [SR_W-1:0]  sr;
    logic             tdo;
    logic             oe;
    logic [BSR_W-1:0] bsr;
    tta_acc_t         acc;
    logic             acc_vld;
  } tta_tap_t;

  localparam tta_tap_t TAP_RESET = '{ir: IR_RESET, default: '0};

  typedef enum {
    TS_RESET, TS_IDLE,
    TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PAU_DR, TS_EX2_DR, TS_UPD_DR,
    TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
  } tta_tap_state_t;

  // data register length seen between tdi and tdo for an instruction
  function automatic int dr_len(input logic [IR_W-1:0] ir, input logic chip);
    case (ir)
      IR_DEVICE_IDENTIFICATION_WORD, IR_USER:   dr_len = ID_LEN;
      IR_EXTEST, IR_SAMPLE: dr_len = chip ? 1 : BSR_W;
      IR_ACCESS:            dr_len = chip ? ACC_LEN : 1;
      default:              dr_len = 1;
    endcase
  endfunction : dr_len

  // shift one bit in at position len-1, lsb falls out towards tdo
  function automatic logic [SR_W-1:0] shift_in(input logic [SR_W-1:0] sr,
                                               input logic            bit_in,
                                               input int              len);
    logic [SR_W-1:0] res;
    res = '0;
    for (int i = 0; i < SR_W - 1; i++) begin
      res[i] = (i == len - 1) ? bit_in : sr[i+1];
    end
    res[SR_W-1] = (len == SR_W) ? bit_in : 1'b0;
    return res;
  endfunction : shift_in

  // tile-side access allowed by the security word
  function automatic logic access_ok(input logic [WORD_W-1:0] sec,
                                     input tta_target_t       target);
    access_ok = !sec[SEC_NO_JTAG] && !(target == TGT_OTP && sec[SEC_NO_OTP]);
  endfunction : access_ok

endpackage : tta_pkg

// *** rtl/tta_tap_fsm.sv ***
// tap controller state sequencer, advanced once per sampled tck rising edge
module tta_tap_fsm
  import tta_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    trst_i,
  input  wire logic                    step_i,
  input  wire logic                    tms_i,
  output tta_pkg::tta_tap_state_t      state_o
);

  tta_tap_state_t state_reg;
  tta_tap_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (trst_i) begin
      state_next = TS_RESET;
    end else if (step_i) begin
      case (state_reg)
        TS_RESET:  state_next = tms_i ? TS_RESET  : TS_IDLE;
        TS_IDLE:   state_next = tms_i ? TS_SEL_DR : TS_IDLE;
        TS_SEL_DR: state_next = tms_i ? TS_SEL_IR : TS_CAP_DR;
        TS_CAP_DR: state_next = tms_i ? TS_EX1_DR : TS_SH_DR;
        TS_SH_DR:  state_next = tms_i ? TS_EX1_DR : TS_SH_DR;
        TS_EX1_DR: state_next = tms_i ? TS_UPD_DR : TS_PAU_DR;
        TS_PAU_DR: state_next = tms_i ? TS_EX2_DR : TS_PAU_DR;
        TS_EX2_DR: state_next = tms_i ? TS_UPD_DR : TS_SH_DR;
        TS_UPD_DR: state_next = tms_i ? TS_SEL_DR : TS_IDLE;
        TS_SEL_IR: state_next = tms_i ? TS_RESET  : TS_CAP_IR;
        TS_CAP_IR: state_next = tms_i ? TS_EX1_IR : TS_SH_IR;
        TS_SH_IR:  state_next = tms_i ? TS_EX1_IR : TS_SH_IR;
        TS_EX1_IR: state_next = tms_i ? TS_UPD_IR : TS_PAU_IR;
        TS_PAU_IR: state_next = tms_i ? TS_EX2_IR : TS_PAU_IR;
        TS_EX2_IR: state_next = tms_i ? TS_UPD_IR : TS_SH_IR;
        TS_UPD_IR: state_next = tms_i ? TS_SEL_DR : TS_IDLE;
        default:   state_next = TS_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= TS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state_o = state_reg;

endmodule : tta_tap_fsm

// *** rtl/tta_top.sv ***
// tile test access port: pin sampling, chained tap controllers, boot release
// Contract
// - after reset the chain holds a boundary tap and a chip tap per tile
// - boundary tap is a standard tap scanning the device pins
// - chip tap reaches tile, switch and one-time memory for loading and debug
// - port supports loading, boundary test, debug and one-time memory programming
// - test reset low keeps the whole test logic in reset
// - identification instruction shifts out the 32-bit identification word
// - user-code instruction shifts out tag, unused field and silicon revision
// - user tag comes from tile 0 security bits 22 to 31, zero if blank
// - global reset is async low; boot waits for pll lock then boot mode
// - security bit 0 blocks all tile access through the test port
// - security bit 13 blocks every one-time memory access from the test port
// - upper security bits extend the user code as its tag field
module tta_top
  import tta_pkg::*;
#(
  parameter logic [3:0]  ID_VERSION  = 4'h1,      // arbitrary value
  parameter logic [15:0] ID_PART     = 16'h0A5C,  // arbitrary value
  parameter logic [10:0] ID_MAKER    = 11'h2B4,   // arbitrary value
  parameter logic [17:0] SILICON_REV = 18'h00003  // arbitrary value
) (
  input  wire logic                                     clk_i,
  input  wire logic                                     reset_n_i,
  input  wire logic                                     tck_i,
  input  wire logic                                     tms_i,
  input  wire logic                                     tdi_i,
  input  wire logic                                     trst_n_i,
  output wire logic                                     tdo_o,
  output wire logic                                     tdo_oe_o,
  input  wire logic [tta_pkg::TILES-1:0][tta_pkg::WORD_W-1:0] sec_word_i,
  input  wire logic [tta_pkg::TILES-1:0][tta_pkg::BSR_W-1:0]  bs_pins_i,
  output wire logic [tta_pkg::TILES-1:0]                bs_drive_o,
  output wire logic [tta_pkg::TILES-1:0][tta_pkg::BSR_W-1:0]  bs_out_o,
  output wire logic [tta_pkg::TILES-1:0]                acc_valid_o,
  output wire tta_pkg::tta_acc_t [tta_pkg::TILES-1:0]   acc_o,
  input  wire logic [tta_pkg::TILES-1:0][tta_pkg::WORD_W-1:0] acc_rdata_i,
  input  wire logic                                     pll_lock_i,
  input  wire logic [tta_pkg::BOOT_W-1:0]               boot_mode_i,
  output wire logic                                     boot_start_o,
  output wire logic [tta_pkg::BOOT_W-1:0]               boot_mode_o
);

  // pin synchroniser: s1 feeds only s2, s3 only serves edge finding
  tta_pins_t pin_s1_reg;
  tta_pins_t pin_s2_reg;
  tta_pins_t pin_s3_reg;
  tta_pins_t pin_s1_next;
  tta_pins_t pin_s2_next;
  tta_pins_t pin_s3_next;

  // boundary pin levels come from outside the clock domain as well
  logic [TILES-1:0][BSR_W-1:0] bsp_s1_reg;
  logic [TILES-1:0][BSR_W-1:0] bsp_s2_reg;
  logic [TILES-1:0][BSR_W-1:0] bsp_s1_next;
  logic [TILES-1:0][BSR_W-1:0] bsp_s2_next;

  logic      tck_rise;
  logic      tck_fall;
  logic      test_rst;

  always_comb begin
    pin_s1_next = '{tck: tck_i, tms: tms_i, tdi: tdi_i, trst_n: trst_n_i};
    pin_s2_next = pin_s1_reg;
    pin_s3_next = pin_s2_reg;
    bsp_s1_next = bs_pins_i;
    bsp_s2_next = bsp_s1_reg;
  end

  // trst_n synchronises as low, so the test logic stays held until a clean high
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
      bsp_s1_reg <= '0;
      bsp_s2_reg <= '0;
    end else begin
      pin_s1_reg <= pin_s1_next;
      pin_s2_reg <= pin_s2_next;
      pin_s3_reg <= pin_s3_next;
      bsp_s1_reg <= bsp_s1_next;
      bsp_s2_reg <= bsp_s2_next;
    end
  end

  assign tck_rise = pin_s2_reg.tck & ~pin_s3_reg.tck;
  assign tck_fall = ~pin_s2_reg.tck & pin_s3_reg.tck;
  assign test_rst = ~pin_s2_reg.trst_n;

  // words returned by the identification and user-code registers; the user-code tag follows the tile 0 security word
  logic [ID_LEN-1:0] id_word;
  logic [ID_LEN-1:0] user_word;

  assign id_word   = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  assign user_word = {sec_word_i[0][TAG_LSB +: TAG_W], UC_UNUSED, SILICON_REV};

  // chain link k carries the tdo of tap k-1 into tap k
  logic [TAPS:0] chain;

  assign chain[0] = pin_s2_reg.tdi;

  genvar k;
  generate
    for (k = 0; k < TAPS; k++) begin : g_tap
      localparam int   TILE = k / 2;
      localparam logic CHIP = 1'((k % 2) == 1);

      tta_tap_state_t st;
      tta_tap_t       t_reg;
      tta_tap_t       t_next;
      tta_acc_t       acc_new;

      tta_tap_fsm u_fsm (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .trst_i    (test_rst),
        .step_i    (tck_rise),
        .tms_i     (pin_s2_reg.tms),
        .state_o   (st)
      );

      assign acc_new = tta_acc_t'(t_reg.sr[ACC_LEN-1:0]);

      always_comb begin
        t_next         = t_reg;
        t_next.acc_vld = 1'b0;
        if (test_rst) begin
          t_next = TAP_RESET;
        end else if (tck_rise) begin
          case (st)
            TS_RESET: begin
              t_next.ir = IR_RESET;
            end
            TS_CAP_IR: begin
              t_next.sr = SR_W'(IR_CAPTURE);
            end
            TS_SH_IR: begin
              t_next.sr = shift_in(t_reg.sr, chain[k], IR_W);
            end
            TS_UPD_IR: begin
              t_next.ir = t_reg.sr[IR_W-1:0];
            end
            TS_CAP_DR: begin
              case (t_reg.ir)
                IR_DEVICE_IDENTIFICATION_WORD: t_next.sr = SR_W'(id_word);
                IR_USER:   t_next.sr = SR_W'(user_word);
                IR_EXTEST, IR_SAMPLE: begin
                  t_next.sr = CHIP ? '0 : SR_W'(bsp_s2_reg[TILE]);
                end
                IR_ACCESS: begin
                  // read data only returns when the security word allows it
                  if (CHIP && access_ok(sec_word_i[TILE], t_reg.acc.target)) begin
                    t_next.sr = {t_reg.acc.target, t_reg.acc.write, t_reg.acc.addr,
                                 acc_rdata_i[TILE]};
                  end else begin
                    t_next.sr = '0;
                  end
                end
                default:   t_next.sr = '0;
              endcase
            end
            TS_SH_DR: begin
              t_next.sr = shift_in(t_reg.sr, chain[k], dr_len(t_reg.ir, CHIP));
            end
            TS_UPD_DR: begin
              if (!CHIP && (t_reg.ir == IR_EXTEST || t_reg.ir == IR_SAMPLE)) begin
                t_next.bsr = t_reg.sr[BSR_W-1:0];
              end
              // blocked requests are dropped silently, keeping the old request
              if (CHIP && t_reg.ir == IR_ACCESS &&
                  access_ok(sec_word_i[TILE], acc_new.target)) begin
                t_next.acc     = acc_new;
                t_next.acc_vld = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end else if (tck_fall) begin
          t_next.tdo = t_reg.sr[0];
          t_next.oe  = (st == TS_SH_IR) || (st == TS_SH_DR);
        end
      end

      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          t_reg <= TAP_RESET;
        end else begin
          t_reg <= t_next;
        end
      end

      assign chain[k+1] = t_reg.tdo;

      if (CHIP) begin : g_chip
        assign acc_valid_o[TILE] = t_reg.acc_vld;
        assign acc_o[TILE]       = t_reg.acc;
      end else begin : g_bscan
        assign bs_drive_o[TILE]  = (t_reg.ir == IR_EXTEST);
        assign bs_out_o[TILE]    = t_reg.bsr;
      end

      if (k == TAPS - 1) begin : g_last
        assign tdo_oe_o = t_reg.oe;
      end
    end
  endgenerate

  assign tdo_o = chain[TAPS];

  // boot release: pll lock and boot strap pass two flops before use
  logic              pll_s1_reg;
  logic              pll_s2_reg;
  logic [BOOT_W-1:0] mode_s1_reg;
  logic [BOOT_W-1:0] mode_s2_reg;
  logic              boot_done_reg;
  logic              boot_start_reg;
  logic [BOOT_W-1:0] boot_mode_reg;
  logic              boot_done_next;
  logic              boot_start_next;
  logic [BOOT_W-1:0] boot_mode_next;

  always_comb begin
    boot_start_next = pll_s2_reg & ~boot_done_reg;
    boot_done_next  = boot_done_reg | pll_s2_reg;
    boot_mode_next  = boot_start_next ? mode_s2_reg : boot_mode_reg;
  end

  // a new reset reopens the wait for lock; the mode is caught at boot time
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pll_s1_reg     <= 1'b0;
      pll_s2_reg     <= 1'b0;
      mode_s1_reg    <= '0;
      mode_s2_reg    <= '0;
      boot_done_reg  <= 1'b0;
      boot_start_reg <= 1'b0;
      boot_mode_reg  <= '0;
    end else begin
      pll_s1_reg     <= pll_lock_i;
      pll_s2_reg     <= pll_s1_reg;
      mode_s1_reg    <= boot_mode_i;
      mode_s2_reg    <= mode_s1_reg;
      boot_done_reg  <= boot_done_next;
      boot_start_reg <= boot_start_next;
      boot_mode_reg  <= boot_mode_next;
    end
  end

  assign boot_start_o = boot_start_reg;
  assign boot_mode_o  = boot_mode_reg;

endmodule : tta_top
